// ==== hw/iocr_pkg.sv ====
// Package: register map and field layout of the I/O cell
package iocr_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_W = 11;
  // Control fields
  localparam int F_CAP_EN = 0;
  localparam int F_IN_LATCH = 1;
  localparam int F_INV_OCLK = 2;
  localparam int F_INV_ICLK = 3;
  localparam int F_OUT_INV = 4;
  localparam int F_T_INV = 5;
  localparam int F_OUT_REG = 6;
  localparam int F_OUT_FALL = 7;
  localparam int F_INIT_SET = 8;
  localparam int F_CE_USED = 9;
  localparam int F_T_USED = 10;
  // Status fields
  localparam int S_CAP = 0;
  localparam int S_IN_Q = 1;
  localparam int S_OUT_Q = 2;
  localparam int S_PAD = 3;
  localparam int S_OE = 4;
  localparam int STATUS_W = 5;
  // Synchroniser lanes
  localparam int L_OCLK = 0;
  localparam int L_ICLK = 1;
  localparam int L_PAD = 2;
  localparam int L_GSC = 3;
  localparam int SYNC_W = 4;
endpackage

// ==== hw/iocr_cell.sv ====
// I/O cell: fast capture, input storage, output flop and three-state
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module iocr_cell (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic out_clk_pin,
  input wire logic in_clk_pin,
  input wire logic global_set_clear,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  input wire logic core_out,
  input wire logic core_ce,
  input wire logic core_t,
  output logic core_in
);

  function automatic logic rose(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // Setup phase of an APB read
  function automatic logic rd_setup(input logic sel, input logic en,
                                    input logic wr);
    return sel & ~en & ~wr;
  endfunction

  logic [10:0] ctrl;
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic oclk_prev;
  logic iclk_prev;
  logic cap;
  logic in_q;
  logic out_q;
  logic oclk;
  logic iclk;
  logic pad_s;
  logic gsc_s;
  logic in_src;
  logic ce_eff;
  logic t_eff;
  logic data_v;
  logic out_edge;
  logic acc;
  logic hit_ctrl;
  logic hit_status;

  // Two-flop synchronisers for pins and outside clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {global_set_clear, pad_in, in_clk_pin, out_clk_pin};
      sync_b <= sync_a;
    end
  end

  assign oclk = sync_b[iocr_pkg::L_OCLK] ^ ctrl[iocr_pkg::F_INV_OCLK];
  assign iclk = sync_b[iocr_pkg::L_ICLK] ^ ctrl[iocr_pkg::F_INV_ICLK];
  assign pad_s = sync_b[iocr_pkg::L_PAD];
  assign gsc_s = sync_b[iocr_pkg::L_GSC];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oclk_prev <= 1'b0;
      iclk_prev <= 1'b0;
    end else begin
      oclk_prev <= oclk;
      iclk_prev <= iclk;
    end
  end

  // APB slave, zero wait states
  assign acc = psel & penable;
  assign hit_ctrl = (paddr == iocr_pkg::ADDR_CTRL);
  assign hit_status = (paddr == iocr_pkg::ADDR_STATUS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= iocr_pkg::CTRL_RESET[10:0];
    end else if (acc && pwrite && hit_ctrl) begin
      ctrl <= pwdata[10:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_ctrl & ~hit_status;
      prdata <= 32'h0000_0000;
      if (rd_setup(psel, penable, pwrite) && hit_ctrl) begin
        prdata <= {21'h00_0000, ctrl};
      end else if (rd_setup(psel, penable, pwrite) && hit_status) begin
        prdata <= {27'h000_0000, pad_oe, pad_s, out_q, in_q, cap};
      end
    end
  end

  // Fast capture latch, transparent while output-side clock low
  // Safe only when both clocks come from one source pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap <= 1'b0;
    end else if (!oclk) begin
      cap <= pad_s;
    end
  end

  assign in_src = ctrl[iocr_pkg::F_CAP_EN] ? cap : pad_s;

  // Input flop on rising edge, or latch transparent while high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_q <= 1'b0;
    end else if (ctrl[iocr_pkg::F_IN_LATCH]) begin
      if (iclk) begin
        in_q <= in_src;
      end
    end else if (rose(iclk, iclk_prev)) begin
      in_q <= in_src;
    end
  end

  assign core_in = in_q;

  // Unconnected enable and three-state fall back to defaults
  assign ce_eff = ctrl[iocr_pkg::F_CE_USED] ? core_ce : 1'b1;
  assign t_eff = ctrl[iocr_pkg::F_T_USED] ?
    (core_t ^ ctrl[iocr_pkg::F_T_INV]) : 1'b0;
  assign data_v = core_out ^ ctrl[iocr_pkg::F_OUT_INV];
  assign out_edge = ctrl[iocr_pkg::F_OUT_FALL] ?
    rose(oclk_prev, oclk) : rose(oclk, oclk_prev);

  // Output flop; reset clear matches the default init value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
    end else if (gsc_s) begin
      out_q <= ctrl[iocr_pkg::F_INIT_SET];
    end else if (out_edge && ce_eff && !t_eff) begin
      out_q <= data_v;
    end
  end

  // Pad driver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
    end else begin
      pad_out <= ctrl[iocr_pkg::F_OUT_REG] ? out_q : data_v;
      pad_oe <= ~t_eff;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_load_cond;
    out_edge && ce_eff && !t_eff && !gsc_s;
  endsequence

  sequence s_hold_cond;
    !out_edge && !gsc_s;
  endsequence

  sequence s_rise_oclk;
    rose(oclk, oclk_prev);
  endsequence

  sequence s_fall_oclk;
    rose(oclk_prev, oclk);
  endsequence

  sequence s_read_setup;
    rd_setup(psel, penable, pwrite);
  endsequence

  sequence s_write_access;
    psel && penable && pwrite;
  endsequence

  // Pad driver, output flop, capture latch and input storage
  chk_oe_float: assert property (t_eff |=> !pad_oe)
    else $error("driver not floated under three-state");
  chk_oe_drive: assert property (!t_eff |=> pad_oe)
    else $error("driver not enabled");
  chk_gsc_init: assert property (
    gsc_s |=> out_q == $past(ctrl[iocr_pkg::F_INIT_SET]))
    else $error("global set/clear did not load init value");
  chk_out_load: assert property (
    s_load_cond |=> out_q == $past(data_v))
    else $error("output flop did not load data");
  chk_out_hold: assert property (s_hold_cond |=> $stable(out_q))
    else $error("output flop changed without active edge");
  chk_ce_default: assert property (
    !ctrl[iocr_pkg::F_CE_USED] && out_edge && !t_eff && !gsc_s
    |=> out_q == $past(data_v))
    else $error("unused enable did not act high");
  chk_fall_edge: assert property (
    ctrl[iocr_pkg::F_OUT_FALL] && rose(oclk, oclk_prev) && !gsc_s
    |=> $stable(out_q))
    else $error("falling mode loaded on rising edge");
  chk_cap_pass: assert property (!oclk |=> cap == $past(pad_s))
    else $error("capture latch not transparent while low");
  chk_cap_hold: assert property (oclk |=> $stable(cap))
    else $error("capture latch changed while closed");
  chk_in_flop: assert property (
    !ctrl[iocr_pkg::F_IN_LATCH] && rose(iclk, iclk_prev)
    |=> in_q == $past(in_src))
    else $error("input flop did not load on rising edge");
  chk_in_latch: assert property (
    ctrl[iocr_pkg::F_IN_LATCH] && iclk |=> in_q == $past(in_src))
    else $error("input latch not transparent while high");
  chk_pad_direct: assert property (
    !ctrl[iocr_pkg::F_OUT_REG] |=> pad_out == $past(data_v))
    else $error("direct output path wrong");
  chk_pad_reg: assert property (
    ctrl[iocr_pkg::F_OUT_REG]
    |=> pad_out == $past(out_q))
    else $error("registered output path wrong");
  chk_data_sense: assert property (
    !ctrl[iocr_pkg::F_OUT_REG]
    |=> pad_out == $past(core_out ^ ctrl[iocr_pkg::F_OUT_INV]))
    else $error("output data sense wrong");
  chk_t_sense: assert property (
    ctrl[iocr_pkg::F_T_USED]
    |=> pad_oe != $past(core_t ^ ctrl[iocr_pkg::F_T_INV]))
    else $error("three-state sense wrong");
  chk_t_default: assert property (
    !ctrl[iocr_pkg::F_T_USED]
    |=> pad_oe)
    else $error("unused three-state did not act low");
  chk_ce_block: assert property (
    ctrl[iocr_pkg::F_CE_USED] && !core_ce && !gsc_s
    |=> $stable(out_q))
    else $error("output flop loaded with enable low");
  chk_t_block: assert property (
    t_eff && !gsc_s
    |=> $stable(out_q))
    else $error("output flop loaded under three-state");
  chk_gsc_wins: assert property (
    gsc_s && out_edge && ce_eff && !t_eff
    |=> out_q == $past(ctrl[iocr_pkg::F_INIT_SET]))
    else $error("data load beat global set/clear");
  chk_rise_load: assert property (
    s_rise_oclk ##0 (!ctrl[iocr_pkg::F_OUT_FALL] && ce_eff && !t_eff &&
    !gsc_s) |=> out_q == $past(data_v))
    else $error("rising mode missed its edge");
  chk_fall_load: assert property (
    s_fall_oclk ##0 (ctrl[iocr_pkg::F_OUT_FALL] && ce_eff && !t_eff &&
    !gsc_s) |=> out_q == $past(data_v))
    else $error("falling mode missed its edge");
  chk_rise_mode: assert property (
    s_fall_oclk ##0 (!ctrl[iocr_pkg::F_OUT_FALL] && !gsc_s)
    |=> $stable(out_q))
    else $error("rising mode loaded on falling edge");

  // Input side
  chk_in_hold: assert property (
    !ctrl[iocr_pkg::F_IN_LATCH] && !rose(iclk, iclk_prev)
    |=> $stable(in_q))
    else $error("input flop changed without rising edge");
  chk_latch_hold: assert property (
    ctrl[iocr_pkg::F_IN_LATCH] && !iclk
    |=> $stable(in_q))
    else $error("input latch changed while closed");
  chk_cap_feed: assert property (
    ctrl[iocr_pkg::F_CAP_EN] && !ctrl[iocr_pkg::F_IN_LATCH] &&
    rose(iclk, iclk_prev) |=> in_q == $past(cap))
    else $error("input flop not fed by capture latch");
  chk_pad_feed: assert property (
    !ctrl[iocr_pkg::F_CAP_EN] && ctrl[iocr_pkg::F_IN_LATCH] && iclk
    |=> in_q == $past(pad_s))
    else $error("input latch not fed by pad");
  chk_oclk_inv: assert property (
    ctrl[iocr_pkg::F_INV_OCLK] && sync_b[iocr_pkg::L_OCLK]
    |=> cap == $past(pad_s))
    else $error("inverted capture clock not applied");
  chk_iclk_inv: assert property (
    ctrl[iocr_pkg::F_INV_ICLK] && ctrl[iocr_pkg::F_IN_LATCH] &&
    !sync_b[iocr_pkg::L_ICLK] |=> in_q == $past(in_src))
    else $error("inverted input clock not applied");
  chk_sync_pipe: assert property (
    sync_b == $past(sync_a))
    else $error("synchroniser stage skipped");

  // Register bus
  chk_apb_ready: assert property (
    psel && !penable
    |=> pready)
    else $error("ready missing in access cycle");
  chk_apb_short: assert property (
    pready
    |=> !pready)
    else $error("ready held longer than one cycle");
  chk_apb_unmapped: assert property (
    psel && !penable && !hit_ctrl && !hit_status
    |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  chk_ctrl_write: assert property (
    s_write_access ##0 hit_ctrl
    |=> ctrl == $past(pwdata[10:0]))
    else $error("control write did not land");
  chk_ctrl_keep: assert property (
    !(psel && penable && pwrite && hit_ctrl)
    |=> $stable(ctrl))
    else $error("control changed without write");
  chk_rd_ctrl: assert property (
    s_read_setup ##0 hit_ctrl
    |=> prdata[10:0] == $past(ctrl) && prdata[31:11] == 21'h00_0000)
    else $error("control read data wrong");
  chk_rd_status: assert property (
    s_read_setup ##0 hit_status
    |=> prdata[iocr_pkg::S_OUT_Q] == $past(out_q))
    else $error("status read data wrong");

endmodule // iocr_cell

// ==== bench/iocr_pad_model.sv ====
// Board-side model of the shared pad wire
`timescale 1ns/1ps
module iocr_pad_model (
  input wire logic pad_out,
  input wire logic pad_oe,
  input wire logic ext_val,
  output logic pad_in
);
  // Board drives the wire only while the cell has let go
  assign pad_in = pad_oe ? pad_out : ext_val;
endmodule // iocr_pad_model

// ==== bench/tb_io_cell_capture_and_output_regs.sv ====
// Testbench: APB access and pad behaviour of the I/O cell
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb_io_cell_capture_and_output_regs;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, oclk = 0, iclk = 0, gsc = 0;
  logic pad_in, pad_out, pad_oe, core_in, ext_val = 0;
  logic core_out = 0, core_ce = 0, core_t = 0;
  int fails = 0, checks = 0;
  always #5 pclk = ~pclk;
  iocr_cell dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .out_clk_pin(oclk), .in_clk_pin(iclk), .global_set_clear(gsc),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .core_out(core_out), .core_ce(core_ce), .core_t(core_t),
    .core_in(core_in));
  iocr_pad_model pad (.pad_out(pad_out), .pad_oe(pad_oe),
    .ext_val(ext_val), .pad_in(pad_in));
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask
  task automatic st(input int b, input logic e);
    apb(0, iocr_pkg::ADDR_STATUS, 32'h0000_0000);
    `CHK(rd[b], e)
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, iocr_pkg::ADDR_CTRL, 32'h0000_0000);
    `CHK(rd, iocr_pkg::CTRL_RESET)
    apb(0, 12'h008, 32'h0000_0000);
    `CHK(err, 1'b1)
    apb(1, iocr_pkg::ADDR_CTRL, 32'h0000_0010);
    settle();
    `CHK(pad_out, 1'b1)
    `CHK(pad_oe, 1'b1)
    apb(1, iocr_pkg::ADDR_CTRL, 32'h0000_0240);
    core_out <= 1;
    oclk <= 1;
    settle();
    st(iocr_pkg::S_OUT_Q, 1'b0);
    oclk <= 0;
    core_ce <= 1;
    settle();
    oclk <= 1;
    settle();
    `CHK(pad_out, 1'b1)
    apb(1, iocr_pkg::ADDR_CTRL, 32'h0000_02C0);
    core_out <= 0;
    oclk <= 0;
    settle();
    `CHK(pad_out, 1'b0)
    apb(1, iocr_pkg::ADDR_CTRL, 32'h0000_03C0);
    gsc <= 1;
    settle();
    st(iocr_pkg::S_OUT_Q, 1'b1);
    gsc <= 0;
    core_t <= 1;
    apb(1, iocr_pkg::ADDR_CTRL, 32'h0000_07C0);
    settle();
    `CHK(pad_oe, 1'b0)
    core_t <= 0;
    apb(1, iocr_pkg::ADDR_CTRL, 32'h0000_0420);
    settle();
    `CHK(pad_oe, 1'b0)
    apb(1, iocr_pkg::ADDR_CTRL, 32'h0000_0421);
    ext_val <= 1;
    settle();
    st(iocr_pkg::S_CAP, 1'b1);
    iclk <= 1;
    settle();
    `CHK(core_in, 1'b1)
    iclk <= 0;
    oclk <= 1;
    ext_val <= 0;
    settle();
    st(iocr_pkg::S_CAP, 1'b1);
    apb(1, iocr_pkg::ADDR_CTRL, 32'h0000_0423);
    iclk <= 1;
    oclk <= 0;
    settle();
    `CHK(core_in, 1'b0)
    apb(1, iocr_pkg::ADDR_CTRL, 32'h0000_0425);
    oclk <= 1;
    ext_val <= 1;
    settle();
    st(iocr_pkg::S_CAP, 1'b1);
    wrap_up();
  end
endmodule // tb_io_cell_capture_and_output_regs
